// file: rtl/bbccr_regs.sv
// Behaviour
// RQ1 - Bits 7:6 of the first output config pick automatic, buck, boost or buck-boost mode.
// RQ2 - Bits 5:4 pick the first output peak current limit of 1000, 750, 500 or 333 mA.
// RQ3 - With discharge bit 3 clear, no discharge load is applied while the first output is off.
// RQ4 - With discharge bit 3 set, the discharge resistor is switched on while the output is off.
// RQ5 - Enable codes 0 to 3 place the first output in power sequencer slots 0 to 3.
// RQ6 - Enable codes 4 and 5 force the first output off, codes 6 and 7 force it on.
// RQ7 - Software sets the bias to normal power before it enables the buck-boost output.
// RQ8 - Software may return the bias to low power once the output is enabled.
// RQ9 - The second output target code maps to 500 mV plus 25 mV per step.
// RQ10 - Codes 0xC8 to 0xFF all give the 5500 mV maximum.
// RQ11 - Both registers are read-write and reset to factory programmed values.
`timescale 1ns/1ps
`default_nettype none
module bbccr_regs (
   input  wire logic                     clock,
   input  wire logic                     sys_rst,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [bbccr_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [bbccr_pkg::APB_DATA_W-1:0] pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [bbccr_pkg::APB_DATA_W-1:0] prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [7:0]               otpFirstCfg,
   input  wire logic [7:0]               otpSecondTv,
   input  wire logic [3:0]               seqSlotOn,
   output bbccr_pkg::bbccr_mode_t        conversionModeSelect,
   output logic      [1:0]               firstOutputPeakCurrentLimit,
   output logic      [9:0]               firstOutputPeakLimitMa,
   output logic                          firstOutputDischargeEnable,
   output logic      [2:0]               firstOutputEnableSlot,
   output logic                          firstOutputOn,
   output logic                          firstOutputDischargeOn,
   output logic      [7:0]               secondOutputTargetVoltage,
   output logic      [12:0]              secondOutputTargetMv,
   output logic                          secondOutputSaturated
);
   import bbccr_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]  otpCfgMeta_reg;
   logic [7:0]  otpCfgSync_reg;
   logic [7:0]  otpTvMeta_reg;
   logic [7:0]  otpTvSync_reg;

   bbccr_bus_t  busState_reg;
   bbccr_bus_t  busState_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        pready_reg;
   logic        pready_next;
   logic        pslverr_reg;
   logic        pslverr_next;

   logic [7:0]  firstCfg_reg;
   logic [7:0]  firstCfg_next;
   logic [7:0]  secondTv_reg;
   logic [7:0]  secondTv_next;

   logic        firstOn_reg;
   logic        firstOn_next;
   logic        dischargeOn_reg;
   logic        dischargeOn_next;
   logic [9:0]  peakLimitMa_reg;
   logic [9:0]  peakLimitMa_next;
   bbccr_mode_t mode_reg;
   bbccr_mode_t mode_next;

   logic        hitCfg;
   logic        hitTv;
   logic        hitStatus;
   logic        hitAny;
   logic [7:0]  statusByte;
   logic [7:0]  readByte;
   logic [12:0] targetMv;
   logic        saturated;

   // ****************************************************************
   // Factory default synchronisers
   // ****************************************************************
   // The defaults are static straps but arrive from outside the clock,
   // so they cross two flops before reset loads them
   always_ff @(posedge clock) begin
      otpCfgMeta_reg <= otpFirstCfg;
      otpCfgSync_reg <= otpCfgMeta_reg;
      otpTvMeta_reg  <= otpSecondTv;
      otpTvSync_reg  <= otpTvMeta_reg;
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   always_comb begin
      hitCfg    = 1'b0;
      hitTv     = 1'b0;
      hitStatus = 1'b0;
      if (paddr == ADDR_FIRST_CFG) begin
         hitCfg = 1'b1;
      end else if (paddr == ADDR_SECOND_TV) begin
         hitTv = 1'b1;
      end else if (paddr == ADDR_STATUS) begin
         hitStatus = 1'b1;
      end
      hitAny = hitCfg | hitTv | hitStatus;
   end

   always_comb begin
      statusByte                 = 8'h00;
      statusByte[STAT_ON_BIT]    = firstOn_reg;
      statusByte[STAT_DISCH_BIT] = dischargeOn_reg;
      statusByte[STAT_SAT_BIT]   = saturated;
      statusByte[STAT_FORCE_BIT] = firstCfg_reg[EN_FORCED_BIT];
      if (hitCfg) begin
         readByte = firstCfg_reg;    // see RQ11
      end else if (hitTv) begin
         readByte = secondTv_reg;    // see RQ11
      end else if (hitStatus) begin
         readByte = statusByte;
      end else begin
         readByte = 8'h00;
      end
   end

   // ****************************************************************
   // APB slave and register writes
   // ****************************************************************
   // One wait state: the answer is registered so every output is a flop
   always_comb begin
      busState_next = busState_reg;
      prdata_next   = prdata_reg;
      pready_next   = 1'b0;
      pslverr_next  = 1'b0;
      firstCfg_next = firstCfg_reg;
      secondTv_next = secondTv_reg;
      case (busState_reg)
         BUS_IDLE: begin
            if (psel && penable) begin
               busState_next = BUS_ACK;
               pready_next   = 1'b1;
               pslverr_next  = ~hitAny;
               if (!pwrite && hitAny) begin
                  prdata_next = {24'h00_0000, readByte};
               end else begin
                  prdata_next = READ_ZERO;
               end
            end
         end
         BUS_ACK: begin
            busState_next = BUS_IDLE;
            // Write lands at the edge that samples pready high
            if (psel && penable && pwrite && pstrb[0]) begin
               if (hitCfg) begin
                  firstCfg_next = pwdata[7:0];    // see RQ11
               end else if (hitTv) begin
                  secondTv_next = pwdata[7:0];    // see RQ11
               end
            end
         end
         default: begin
            busState_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         busState_reg <= BUS_IDLE;
         prdata_reg   <= READ_ZERO;
         pready_reg   <= 1'b0;
         pslverr_reg  <= 1'b0;
         // Factory values, not constants; reset must outlast the sync chain
         firstCfg_reg <= otpCfgSync_reg;    // see RQ11
         secondTv_reg <= otpTvSync_reg;     // see RQ11
      end else begin
         busState_reg <= busState_next;
         prdata_reg   <= prdata_next;
         pready_reg   <= pready_next;
         pslverr_reg  <= pslverr_next;
         firstCfg_reg <= firstCfg_next;
         secondTv_reg <= secondTv_next;
      end
   end

   // ****************************************************************
   // First output decode
   // ****************************************************************
   always_comb begin
      mode_next = bbccr_mode_t'(firstCfg_reg[MODE_MSB:MODE_LSB]);    // see RQ1
      case (firstCfg_reg[ILIM_MSB:ILIM_LSB])
         2'b00:   peakLimitMa_next = ILIM_MA_CODE0;    // see RQ2
         2'b01:   peakLimitMa_next = ILIM_MA_CODE1;    // see RQ2
         2'b10:   peakLimitMa_next = ILIM_MA_CODE2;    // see RQ2
         default: peakLimitMa_next = ILIM_MA_CODE3;    // see RQ2
      endcase
      if (firstCfg_reg[EN_FORCED_BIT]) begin
         // Forced codes ignore the sequencer entirely
         firstOn_next = firstCfg_reg[EN_FORCE_ON];    // see RQ6
      end else begin
         firstOn_next = seqSlotOn[firstCfg_reg[EN_FORCE_ON:EN_LSB]];    // see RQ5
      end
      // Discharge only while off, and only if enabled
      dischargeOn_next = firstCfg_reg[DISCH_BIT] & ~firstOn_next;    // see RQ3 see RQ4
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mode_reg        <= MODE_AUTO;
         peakLimitMa_reg <= ILIM_MA_CODE0;
         firstOn_reg     <= 1'b0;
         dischargeOn_reg <= 1'b0;
      end else begin
         mode_reg        <= mode_next;
         peakLimitMa_reg <= peakLimitMa_next;
         firstOn_reg     <= firstOn_next;
         dischargeOn_reg <= dischargeOn_next;
      end
   end

   // ****************************************************************
   // Second output voltage map
   // ****************************************************************
   bbccr_vout_map u_vout_map (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .targetCode (secondTv_reg),
      .targetMv   (targetMv),
      .saturated  (saturated)
   );

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata                      = prdata_reg;
   assign pready                      = pready_reg;
   assign pslverr                     = pslverr_reg;
   assign conversionModeSelect        = mode_reg;
   assign firstOutputPeakCurrentLimit = firstCfg_reg[ILIM_MSB:ILIM_LSB];
   assign firstOutputPeakLimitMa      = peakLimitMa_reg;
   assign firstOutputDischargeEnable  = firstCfg_reg[DISCH_BIT];
   assign firstOutputEnableSlot       = firstCfg_reg[EN_MSB:EN_LSB];
   assign firstOutputOn               = firstOn_reg;
   assign firstOutputDischargeOn      = dischargeOn_reg;
   assign secondOutputTargetVoltage   = secondTv_reg;
   assign secondOutputTargetMv        = targetMv;
   assign secondOutputSaturated       = saturated;

endmodule : bbccr_regs
`default_nettype wire

// file: rtl/bbccr_pkg.sv
package bbccr_pkg;

   // ****************************************************************
   // APB address map
   // ****************************************************************
   localparam int          APB_ADDR_W     = 12;
   localparam int          APB_DATA_W     = 32;
   // Printed offsets are register indices; byte address is four times that
   localparam logic [7:0]  IDX_FIRST_CFG  = 8'h2c;
   localparam logic [7:0]  IDX_SECOND_TV  = 8'h2d;
   localparam logic [7:0]  IDX_STATUS     = 8'h30;
   localparam logic [11:0] ADDR_FIRST_CFG = {2'b00, IDX_FIRST_CFG, 2'b00};
   localparam logic [11:0] ADDR_SECOND_TV = {2'b00, IDX_SECOND_TV, 2'b00};
   localparam logic [11:0] ADDR_STATUS    = {2'b00, IDX_STATUS, 2'b00};
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

   // ****************************************************************
   // First output config field positions
   // ****************************************************************
   localparam int          MODE_MSB       = 7;
   localparam int          MODE_LSB       = 6;
   localparam int          ILIM_MSB       = 5;
   localparam int          ILIM_LSB       = 4;
   localparam int          DISCH_BIT      = 3;
   localparam int          EN_MSB         = 2;
   localparam int          EN_LSB         = 0;
   localparam int          EN_FORCED_BIT  = 2;
   localparam int          EN_FORCE_ON    = 1;

   // ****************************************************************
   // Status register field positions
   // ****************************************************************
   localparam int          STAT_ON_BIT    = 0;
   localparam int          STAT_DISCH_BIT = 1;
   localparam int          STAT_SAT_BIT   = 2;
   localparam int          STAT_FORCE_BIT = 3;

   // ****************************************************************
   // Decode values
   // ****************************************************************
   localparam logic [9:0]  ILIM_MA_CODE0  = 10'h3e8;
   localparam logic [9:0]  ILIM_MA_CODE1  = 10'h2ee;
   localparam logic [9:0]  ILIM_MA_CODE2  = 10'h1f4;
   localparam logic [9:0]  ILIM_MA_CODE3  = 10'h14d;
   localparam logic [12:0] VOUT_BASE_MV   = 13'h01f4;
   localparam logic [12:0] VOUT_STEP_MV   = 13'h0019;
   localparam logic [12:0] VOUT_MAX_MV    = 13'h157c;
   localparam logic [7:0]  VOUT_SAT_CODE  = 8'hc8;

   // ****************************************************************
   // Reset
   // ****************************************************************
   // Reset must cover the two-flop sync of the factory defaults
   localparam int          RST_HOLD_CYCLES = 3;

   typedef enum logic [1:0] {
      MODE_AUTO      = 2'b00,
      MODE_BUCK      = 2'b01,
      MODE_BOOST     = 2'b10,
      MODE_BUCKBOOST = 2'b11
   } bbccr_mode_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bbccr_bus_t;

endpackage : bbccr_pkg

// file: rtl/bbccr_vout_map.sv
`timescale 1ns/1ps
`default_nettype none
module bbccr_vout_map (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  targetCode,
   output logic      [12:0] targetMv,
   output logic             saturated
);
   import bbccr_pkg::*;

   logic [12:0] targetMv_reg;
   logic [12:0] targetMv_next;
   logic        saturated_reg;
   logic        saturated_next;

   // ****************************************************************
   // Linear code to millivolt map
   // ****************************************************************
   always_comb begin
      saturated_next = (targetCode >= VOUT_SAT_CODE);   // see RQ10
      if (saturated_next) begin
         targetMv_next = VOUT_MAX_MV;                   // see RQ10
      end else begin
         // Product fits 13 bits for every 8-bit code; this branch sees only codes below saturation
         targetMv_next = VOUT_BASE_MV + 13'(targetCode) * VOUT_STEP_MV;   // see RQ9
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         targetMv_reg  <= VOUT_BASE_MV;
         saturated_reg <= 1'b0;
      end else begin
         targetMv_reg  <= targetMv_next;
         saturated_reg <= saturated_next;
      end
   end

   assign targetMv  = targetMv_reg;
   assign saturated = saturated_reg;

endmodule : bbccr_vout_map
`default_nettype wire

// file: verif/bbccr_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module bbccr_regs_props (
   input wire logic                   clock,
   input wire logic                   sys_rst,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [3:0]             pstrb,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [3:0]             seqSlotOn,
   input wire logic [1:0]             firstOutputPeakCurrentLimit,
   input wire logic [9:0]             firstOutputPeakLimitMa,
   input wire logic                   firstOutputDischargeEnable,
   input wire logic [2:0]             firstOutputEnableSlot,
   input wire logic                   firstOutputOn,
   input wire logic                   firstOutputDischargeOn,
   input wire logic [7:0]             secondOutputTargetVoltage,
   input wire logic [12:0]            secondOutputTargetMv,
   input wire logic                   secondOutputSaturated
);
   import bbccr_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // ****************************************************************
   // Decode references
   // ****************************************************************
   function automatic logic [9:0] ilimMa(input logic [1:0] c);
      return c[1] ? (c[0] ? ILIM_MA_CODE3 : ILIM_MA_CODE2) : (c[0] ? ILIM_MA_CODE1 : ILIM_MA_CODE0);
   endfunction : ilimMa
   function automatic logic [12:0] mvOf(input logic [7:0] c);
      return (c >= VOUT_SAT_CODE) ? VOUT_MAX_MV : VOUT_BASE_MV + VOUT_STEP_MV * {5'h00, c};
   endfunction : mvOf

   // ****************************************************************
   // Properties
   // ****************************************************************
   // Guard on past reset: decoded outputs hold defaults while reset is high
   property p_ilim;
      !$past(sys_rst) |-> firstOutputPeakLimitMa == ilimMa($past(firstOutputPeakCurrentLimit));
   endproperty
   a_ilim: assert property (p_ilim) else $error("peak limit decode wrong");
   property p_on;
      !$past(sys_rst) |-> firstOutputOn == ($past(firstOutputEnableSlot[2]) ?
         $past(firstOutputEnableSlot[1]) : $past(seqSlotOn[firstOutputEnableSlot[1:0]]));
   endproperty
   a_on: assert property (p_on) else $error("output on decision wrong");
   property p_dis;
      !$past(sys_rst) |-> firstOutputDischargeOn == ($past(firstOutputDischargeEnable) && !firstOutputOn);
   endproperty
   a_dis: assert property (p_dis) else $error("discharge wrong");
   property p_nodis;
      !$past(sys_rst) && !$past(firstOutputDischargeEnable) |-> !firstOutputDischargeOn;
   endproperty
   a_nodis: assert property (p_nodis) else $error("discharge while disabled");
   property p_mv;
      !$past(sys_rst) |-> secondOutputTargetMv == mvOf($past(secondOutputTargetVoltage));
   endproperty
   a_mv: assert property (p_mv) else $error("target mV wrong");
   property p_sat;
      !$past(sys_rst) |-> secondOutputSaturated == ($past(secondOutputTargetVoltage) >= VOUT_SAT_CODE);
   endproperty
   a_sat: assert property (p_sat) else $error("saturation flag wrong");
   property p_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer timing wrong");
   property p_wr;
      psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_SECOND_TV
         |=> secondOutputTargetVoltage == $past(pwdata[7:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("target write lost");
   property p_err;
      pslverr && !pwrite |-> pready && prdata == READ_ZERO;
   endproperty
   a_err: assert property (p_err) else $error("error read not zero");
   c_err: cover property (pslverr);
   c_force: cover property (firstOutputOn && firstOutputEnableSlot[2]);
   c_sat: cover property (secondOutputSaturated);
endmodule : bbccr_regs_props
bind bbccr_regs bbccr_regs_props u_props (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .seqSlotOn, .firstOutputPeakCurrentLimit,
   .firstOutputPeakLimitMa, .firstOutputDischargeEnable, .firstOutputEnableSlot, .firstOutputOn,
   .firstOutputDischargeOn, .secondOutputTargetVoltage, .secondOutputTargetMv,
   .secondOutputSaturated);
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bbccr_pkg::*;
   logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, seqSlotOn;
   logic [7:0]  otpFirstCfg, otpSecondTv, secondOutputTargetVoltage;
   logic [1:0]  firstOutputPeakCurrentLimit;
   logic [9:0]  firstOutputPeakLimitMa;
   logic [2:0]  firstOutputEnableSlot;
   logic [12:0] secondOutputTargetMv;
   logic        firstOutputDischargeEnable, firstOutputOn, firstOutputDischargeOn;
   logic        secondOutputSaturated;
   bbccr_mode_t conversionModeSelect;
   int          badCount, nCompared, cycles;
   logic [9:0]  ilim [4] = '{ILIM_MA_CODE0, ILIM_MA_CODE1, ILIM_MA_CODE2, ILIM_MA_CODE3};
   logic [7:0]  codes [6] = '{8'h00, 8'h01, 8'h7f, 8'hc7, 8'hc8, 8'hff};
   // Millivolts per code, worked out by hand from base plus step
   logic [12:0] mvExp [6] = '{13'h01f4, 13'h020d, 13'h0e5b, 13'h1563, 13'h157c, 13'h157c};

   bbccr_regs DUT (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .otpFirstCfg, .otpSecondTv, .seqSlotOn, .conversionModeSelect,
      .firstOutputPeakCurrentLimit, .firstOutputPeakLimitMa, .firstOutputDischargeEnable,
      .firstOutputEnableSlot, .firstOutputOn, .firstOutputDischargeOn,
      .secondOutputTargetVoltage, .secondOutputTargetMv, .secondOutputSaturated);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      if (badCount == 0 && nCompared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test
   // Starts on an edge so back-to-back calls never drive a signal twice per step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      @(posedge clock);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h00_0000, d}; pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask : settle

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      settle();
      check(conversionModeSelect, MODE_BOOST);
      check(firstOutputPeakLimitMa, ILIM_MA_CODE1);
      check({firstOutputOn, firstOutputDischargeOn}, 2'b10);
      check({secondOutputSaturated, secondOutputTargetMv}, {1'b1, VOUT_MAX_MV});
      apb(1'b0, ADDR_FIRST_CFG, 8'h00, 4'h1);
      check(rd, 32'h0000_009e);
      apb(1'b0, ADDR_SECOND_TV, 8'h00, 4'h1);
      check(rd, 32'h0000_00c9);
   endtask : t_reset
   task automatic t_cfg;
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, ADDR_FIRST_CFG, {i[3:0], 4'h4}, 4'h1);
         settle();
         check(conversionModeSelect, i[3:2]);
         check(firstOutputPeakLimitMa, ilim[i[1:0]]);
         check(firstOutputPeakCurrentLimit, i[1:0]);
         apb(1'b0, ADDR_FIRST_CFG, 8'h00, 4'h1);
         check(rd, {24'h00_0000, i[3:0], 4'h4});
      end
   endtask : t_cfg
   // No bias control lives here; the test drives only the enable code, the discharge bit and the sequencer slots
   task automatic t_enable;
      logic expOn;
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, ADDR_FIRST_CFG, {4'h0, i[3:0]}, 4'h1);
         @(posedge clock);
         seqSlotOn <= i[4] ? 4'ha : 4'h5;
         settle();
         expOn = i[2] ? i[1] : (i[4] ? i[0] : !i[0]);
         check(firstOutputEnableSlot, i[2:0]);
         check(firstOutputDischargeEnable, i[3]);
         check(firstOutputOn, expOn);
         check(firstOutputDischargeOn, i[3] & !expOn);
      end
   endtask : t_enable
   task automatic t_vout;
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ADDR_SECOND_TV, codes[i], 4'h1);
         settle();
         check(secondOutputTargetVoltage, codes[i]);
         check(secondOutputTargetMv, mvExp[i]);
         check(secondOutputSaturated, codes[i] >= 8'hc8);
      end
   endtask : t_vout
   task automatic t_bus;
      apb(1'b0, 12'h0fc, 8'h00, 4'h1);
      check(err, 1'b1);
      check(rd, READ_ZERO);
      apb(1'b1, 12'h0fc, 8'h33, 4'h1);
      check(err, 1'b1);
      apb(1'b1, ADDR_SECOND_TV, 8'h44, 4'h0);
      check(err, 1'b0);
      apb(1'b0, ADDR_SECOND_TV, 8'h00, 4'h1);
      check(rd, 32'h0000_00ff);
      // Forced on, no discharge, saturated target, forced code
      apb(1'b0, ADDR_STATUS, 8'h00, 4'h1);
      check(rd, 32'h0000_000d);
      apb(1'b1, ADDR_STATUS, 8'hff, 4'h1);
      check(err, 1'b0);
      apb(1'b0, ADDR_STATUS, 8'h00, 4'h1);
      check(rd, 32'h0000_000d);
   endtask : t_bus
   // Second reset reloads the factory values over what software wrote
   task automatic t_rerst;
      @(posedge clock);
      otpFirstCfg <= 8'h5a;
      otpSecondTv <= 8'h28;
      sys_rst     <= 1'b1;
      repeat (RST_HOLD_CYCLES) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      check(conversionModeSelect, MODE_AUTO);
      check({secondOutputSaturated, secondOutputTargetMv}, {1'b0, VOUT_BASE_MV});
      settle();
      check(conversionModeSelect, MODE_BUCK);
      check(firstOutputPeakLimitMa, ILIM_MA_CODE1);
      check({firstOutputOn, firstOutputDischargeOn}, 2'b01);
      check(secondOutputTargetMv, 13'h05dc);
      apb(1'b0, ADDR_FIRST_CFG, 8'h00, 4'h1);
      check(rd, 32'h0000_005a);
      apb(1'b0, ADDR_SECOND_TV, 8'h00, 4'h1);
      check(rd, 32'h0000_0028);
   endtask : t_rerst

   // ****************************************************************
   // Run
   // ****************************************************************
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         finish_test();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, seqSlotOn} = '0;
      otpFirstCfg = 8'h9e;
      otpSecondTv = 8'hc9;
      // Reset outlasts the two-flop sync of the factory values
      sys_rst = 1'b1;
      repeat (RST_HOLD_CYCLES) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_cfg();
      t_enable();
      t_vout();
      t_bus();
      t_rerst();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
